// >>> bench/dpi2c_master_model.sv
// bus master model: drives scl and its own side of sda
// assumes the bench wires sda as a wired-and with pull-up
`timescale 1ns/100ps
`default_nettype none

module dpi2c_master_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // ---------------------------------------------------------------
  // bus phases, one bit is 20 clocks (160 ns)
  // ---------------------------------------------------------------
  // idle bus: both lines released, scl stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // step off the edge so the slave never races the driver
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // start or repeated start, entered with scl low or idle
  task automatic start();
    sda_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    sda_o = 1'b0;
    tick(10);
    scl_o = 1'b0;
  endtask

  // stop ends every frame and leaves the bus idle
  task automatic stop();
    tick(5);
    sda_o = 1'b0;
    tick(5);
    scl_o = 1'b1;
    tick(10);
    sda_o = 1'b1;
    tick(10);
  endtask

  // sda moves mid-way through scl low, sampled mid scl high
  task automatic bit_io(input logic tx, output logic rx);
    tick(5);
    sda_o = tx;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    rx = sda_i;
    tick(5);
    scl_o = 1'b0;
  endtask

  // eight bits then the acknowledge clock; tx of ff releases sda
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_tx, ack_rx);
  endtask
endmodule
`default_nettype wire

// >>> bench/dpi2c_slave_tb_top.sv
// self-checking bench of the potentiometer i2c slave port
// assumes the master model in bench/ and the package in inc/
`timescale 1ns/100ps
`default_nettype none

module dpi2c_slave_tb_top
  import dpi2c_pkg::*;
;

  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic       clock;
  logic       resetn;
  logic       clk_en;
  logic [2:0] pins;
  logic       scl;
  logic       m_sda;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] wiper0;
  logic [7:0] wiper1;
  logic       pd_n;
  int         errors;
  int         comparisons;

  // wired-and of both pull-downs, pull-up when released
  assign sda_wire = m_sda & ~(sda_oe & ~sda_out);

  dpi2c_slave i_dpi2c_slave (
    .clock_i         (clock),
    .resetn_i        (resetn),
    .clk_en_i        (clk_en),
    .scl_i           (scl),
    .sda_i           (sda_wire),
    .addr_pin_bit2_i (pins[2]),
    .addr_pin_bit1_i (pins[1]),
    .addr_pin_bit0_i (pins[0]),
    .sda_o           (sda_out),
    .sda_oe_o        (sda_oe),
    .wiper_pos_ch0_o (wiper0),
    .wiper_pos_ch1_o (wiper1),
    .power_down_n_o  (pd_n)
  );

  dpi2c_master_model i_dpi2c_master_model (
    .clock_i (clock),
    .sda_i   (sda_wire),
    .scl_o   (scl),
    .sda_o   (m_sda)
  );

  // 125 mhz system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] id(input logic rd);
    return {ID_PREFIX, pins, rd};
  endfunction

  task automatic reset_dut();
    resetn = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    resetn = 1'b1;
  endtask

  // one byte to the slave; exp_ack of 1 means no acknowledge
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    i_dpi2c_master_model.xfer(b, 1'b1, rx, ack);
    check("ack", {7'h0, exp_ack}, {7'h0, ack});
  endtask

  // one byte from the slave; last leaves the ack high
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    i_dpi2c_master_model.xfer(8'hff, last, rx, ack);
    check("read data", exp, rx);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b0);
    send(a, 1'b0);
    send(d, 1'b0);
    i_dpi2c_master_model.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b0);
    send(a, 1'b0);
    i_dpi2c_master_model.start();
    send(id(1'b1), 1'b0);
    recv(1'b1, exp);
    i_dpi2c_master_model.stop();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("wiper0", WIPER_RST, wiper0);
    check("wiper1", 8'h80, wiper1);
    check("power down n", 8'h01, {7'h0, pd_n});
    check("sda oe", 8'h00, {7'h0, sda_oe});
    check("sda level", 8'h00, {7'h0, sda_out});
  endtask

  // start lands inside the power-up interval, whole frame ignored
  task automatic t_powerup();
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h33, 1'b1);
    i_dpi2c_master_model.stop();
    check("wiper0", 8'h80, wiper0);
  endtask

  // stored at the ack clock, before any stop is seen
  task automatic t_write();
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b0);
    send(8'h00, 1'b0);
    send(8'h5a, 1'b0);
    check("wiper0", 8'h5a, wiper0);
    i_dpi2c_master_model.stop();
    check("sda oe", 8'h00, {7'h0, sda_oe});
  endtask

  task automatic t_seq();
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b0);
    send(8'h00, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    i_dpi2c_master_model.stop();
    check("wiper0", 8'h11, wiper0);
    check("wiper1", 8'h22, wiper1);
  endtask

  // two bytes read back, master ack then nack
  task automatic t_read();
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b0);
    send(8'h00, 1'b0);
    i_dpi2c_master_model.start();
    send(id(1'b1), 1'b0);
    recv(1'b0, 8'h11);
    recv(1'b1, 8'h22);
    check("sda oe", 8'h00, {7'h0, sda_oe});
    i_dpi2c_master_model.stop();
  endtask

  // wrong prefix or any strap bit flipped gets no ack
  task automatic t_ident();
    logic [7:0] masks [4];
    masks = '{8'h10, 8'h08, 8'h04, 8'h02};
    foreach (masks[k]) begin
      i_dpi2c_master_model.start();
      send(id(1'b0) ^ masks[k], 1'b1);
      i_dpi2c_master_model.stop();
    end
    pins = 3'h2;
    wr(8'h01, 8'hc3);
    check("wiper1", 8'hc3, wiper1);
  endtask

  // only bit 6 of the control register exists
  task automatic t_ctrl();
    wr(REG_CTRL, 8'hbf);
    check("power down n", 8'h00, {7'h0, pd_n});
    rd(8'h10, 8'h00);
    wr(8'h10, 8'hff);
    check("power down n", 8'h01, {7'h0, pd_n});
    rd(8'h10, 8'h40);
    rd(8'h05, 8'h00);
    rd(8'h01, 8'hc3);
    check("wiper0", 8'h11, wiper0);
  endtask

  // clock enable low freezes the port; a frame meanwhile is not seen
  task automatic t_freeze();
    clk_en = 1'b0;
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b1);
    i_dpi2c_master_model.stop();
    check("sda oe", 8'h00, {7'h0, sda_oe});
    clk_en = 1'b1;
    wr(8'h01, 8'h99);
    check("wiper1", 8'h99, wiper1);
  endtask

  // second reset mid-run brings back mid-scale
  task automatic t_rereset();
    reset_dut();
    check("wiper0", 8'h80, wiper0);
    check("wiper1", 8'h80, wiper1);
    check("power down n", 8'h01, {7'h0, pd_n});
    // power-up interval runs again, so an early frame is ignored
    i_dpi2c_master_model.start();
    send(id(1'b0), 1'b1);
    i_dpi2c_master_model.stop();
    wr(8'h00, 8'h3c);
    check("wiper0", 8'h3c, wiper0);
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // about 52 bytes of 180 clocks each; generous margin for a hang
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    final_report();
  end

  initial begin
    errors      = 0;
    comparisons = 0;
    resetn      = 1'b0;
    clk_en      = 1'b1;
    pins        = 3'h5;
    reset_dut();
    t_reset();
    t_powerup();
    t_write();
    t_seq();
    t_read();
    t_ident();
    t_ctrl();
    t_freeze();
    t_rereset();
    final_report();
  end
endmodule
`default_nettype wire

// >>> inc/dpi2c_pkg.sv
// constants and types of the potentiometer i2c slave port
// assumes a 125 mhz system clock that samples the bus pins
package dpi2c_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned POWERUP_NS    = 1000;
  // least time, so round up
  localparam int unsigned POWERUP_CYC   =
    (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_CNT_W     = $clog2(POWERUP_CYC + 1);

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [3:0] ID_PREFIX     = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SEEN      = 4'h1;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_WIPER0 = 8'h00;
  localparam logic [7:0] REG_WIPER1 = 8'h01;
  localparam logic [7:0] REG_CTRL   = 8'h10;
  localparam logic [7:0] WIPER_RST  = 8'h80;
  localparam logic [7:0] CTRL_RST   = 8'h40;
  localparam logic [7:0] CTRL_WMASK = 8'h40;
  localparam int unsigned CTRL_PD_BIT = 6;

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_SACK = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } dpi2c_state_type;

  typedef enum logic [2:0] {
    PH_ID   = 3'h1,
    PH_REG  = 3'h2,
    PH_DATA = 3'h4
  } dpi2c_phase_type;

endpackage

// >>> rtl/dpi2c_slave.sv
// i2c slave register port of a dual digital potentiometer
// assumes open-drain wiring outside and scl far slower than clock_i
//
// Summary of operation
// - every byte is shifted most significant bit first.
// - sda changes only with scl low; else start or stop.
// - after reset the sda driver stays released.
// - nothing happens until a start (sda falls, scl high).
// - a start during the power-up interval is ignored.
// - a stop (sda rises, scl high) returns to idle.
// - transmitter releases after eight bits; receiver acks ninth.
// - id, register address and write data bytes are acked.
// - id is 1010, then address pins, then read/write bit.
// - write data is stored at the ninth clock of its byte.
// - extra data bytes write successive registers.
// - read uses id, address, repeated start, id with read.
// - wipers at 00h and 01h, control register at 10h.
// - both wipers reset to mid-scale 80h.
// - control bit 6 is active-low power down, reset 40h.
`timescale 1ns/100ps
`default_nettype none

module dpi2c_slave
  import dpi2c_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       addr_pin_bit2_i,
  input  wire logic       addr_pin_bit1_i,
  input  wire logic       addr_pin_bit0_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic      [7:0] wiper_pos_ch0_o,
  output logic      [7:0] wiper_pos_ch1_o,
  output logic            power_down_n_o
);

  // ---------------------------------------------------------------
  // pin sampling and bus events
  // ---------------------------------------------------------------
  logic [4:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] addr_s;

  dpi2c_sync #(
    .WIDTH       (5),
    .RESET_VALUE (5'h1f)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .async_i  ({scl_i, sda_i, addr_pin_bit2_i,
                addr_pin_bit1_i, addr_pin_bit0_i}),
    .sync_o   (pins_s)
  );

  assign scl_s  = pins_s[4];
  assign sda_s  = pins_s[3];
  assign addr_s = pins_s[2:0];

  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // line changes while scl stays high are markers, not data
  assign scl_rise   = scl_s & ~scl_q_ff;
  assign scl_fall   = ~scl_s & scl_q_ff;
  assign start_seen = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_seen  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_read(
    input logic [7:0] ptr,
    input logic [7:0] w0,
    input logic [7:0] w1,
    input logic [7:0] ctrl
  );
    logic [7:0] val;
    val = 8'h00;
    // unmapped addresses read as zero
    case (ptr)
      REG_WIPER0: val = w0;
      REG_WIPER1: val = w1;
      REG_CTRL:   val = ctrl;
      default:    val = 8'h00;
    endcase
    return val;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dpi2c_state_type      state_ff;
  dpi2c_state_type      nxt_state;
  dpi2c_phase_type      phase_ff;
  dpi2c_phase_type      nxt_phase;
  logic [3:0]           bits_ff;
  logic [3:0]           nxt_bits;
  logic [7:0]           shift_ff;
  logic [7:0]           nxt_shift;
  logic                 oe_ff;
  logic                 nxt_oe;
  logic [7:0]           ptr_ff;
  logic [7:0]           nxt_ptr;
  logic [7:0]           wiper0_ff;
  logic [7:0]           nxt_wiper0;
  logic [7:0]           wiper1_ff;
  logic [7:0]           nxt_wiper1;
  logic [7:0]           ctrl_ff;
  logic [7:0]           nxt_ctrl;
  logic [PWR_CNT_W-1:0] pwr_cnt_ff;
  logic [PWR_CNT_W-1:0] nxt_pwr_cnt;
  logic                 pwr_done;
  logic                 id_ok;
  logic [7:0]           rd_val;

  assign pwr_done = (pwr_cnt_ff == PWR_CNT_W'(POWERUP_CYC));
  assign id_ok    = (shift_ff[7:4] == ID_PREFIX) &&
                    (shift_ff[3:1] == addr_s);
  assign rd_val   = reg_read(ptr_ff, wiper0_ff, wiper1_ff, ctrl_ff);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // one event per sampled cycle; stop and start take priority
  always_comb begin
    nxt_state   = state_ff;
    nxt_phase   = phase_ff;
    nxt_bits    = bits_ff;
    nxt_shift   = shift_ff;
    nxt_oe      = oe_ff;
    nxt_ptr     = ptr_ff;
    nxt_wiper0  = wiper0_ff;
    nxt_wiper1  = wiper1_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_pwr_cnt = pwr_cnt_ff;
    if (!pwr_done) begin
      nxt_pwr_cnt = pwr_cnt_ff + PWR_CNT_W'(1);
    end
    if (stop_seen) begin
      nxt_state = ST_IDLE;
      nxt_oe    = 1'b0;
    end else if (start_seen && pwr_done) begin
      // also serves as the repeated start of a read
      nxt_state = ST_RECV;
      nxt_phase = PH_ID;
      nxt_bits  = 4'h0;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && bits_ff != BITS_PER_BYTE) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bits  = bits_ff + 4'h1;
          end else if (scl_fall && bits_ff == BITS_PER_BYTE) begin
            nxt_bits = 4'h0;
            if (phase_ff == PH_ID && !id_ok) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_state = ST_SACK;
              nxt_oe    = 1'b1;
            end
          end
        end
        ST_SACK: begin
          if (scl_rise && phase_ff == PH_DATA) begin
            // store on the ninth clock edge
            case (ptr_ff)
              REG_WIPER0: nxt_wiper0 = shift_ff;
              REG_WIPER1: nxt_wiper1 = shift_ff;
              REG_CTRL:   nxt_ctrl   = shift_ff & CTRL_WMASK;
              default:    nxt_ctrl   = ctrl_ff;
            endcase
          end else if (scl_fall) begin
            nxt_oe    = 1'b0;
            nxt_state = ST_RECV;
            case (phase_ff)
              PH_ID: begin
                if (shift_ff[0]) begin
                  nxt_state = ST_SEND;
                  nxt_shift = rd_val;
                  nxt_oe    = ~rd_val[7];
                end else begin
                  nxt_phase = PH_REG;
                end
              end
              PH_REG: begin
                nxt_ptr   = shift_ff;
                nxt_phase = PH_DATA;
              end
              PH_DATA: begin
                nxt_ptr = ptr_ff + 8'h01;
              end
              default: begin
                nxt_state = ST_IDLE;
              end
            endcase
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            nxt_bits = bits_ff + 4'h1;
          end else if (scl_fall) begin
            if (bits_ff == BITS_PER_BYTE) begin
              nxt_oe    = 1'b0;
              nxt_bits  = 4'h0;
              nxt_state = ST_MACK;
              nxt_ptr   = ptr_ff + 8'h01;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe    = ~shift_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_bits = ACK_SEEN;
            end
          end else if (scl_fall && bits_ff == ACK_SEEN) begin
            nxt_state = ST_SEND;
            nxt_bits  = 4'h0;
            nxt_shift = rd_val;
            nxt_oe    = ~rd_val[7];
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // clock enable low freezes every flop in this block, edge history included
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scl_q_ff   <= 1'b1;
      sda_q_ff   <= 1'b1;
      state_ff   <= ST_IDLE;
      phase_ff   <= PH_ID;
      bits_ff    <= 4'h0;
      shift_ff   <= 8'h00;
      oe_ff      <= 1'b0;
      ptr_ff     <= REG_WIPER0;
      wiper0_ff  <= WIPER_RST;
      wiper1_ff  <= WIPER_RST;
      ctrl_ff    <= CTRL_RST;
      pwr_cnt_ff <= '0;
    end else if (clk_en_i) begin
      scl_q_ff   <= scl_s;
      sda_q_ff   <= sda_s;
      state_ff   <= nxt_state;
      phase_ff   <= nxt_phase;
      bits_ff    <= nxt_bits;
      shift_ff   <= nxt_shift;
      oe_ff      <= nxt_oe;
      ptr_ff     <= nxt_ptr;
      wiper0_ff  <= nxt_wiper0;
      wiper1_ff  <= nxt_wiper1;
      ctrl_ff    <= nxt_ctrl;
      pwr_cnt_ff <= nxt_pwr_cnt;
    end
  end

  // open drain: the data level is always low, only enable moves
  logic sda_lvl_ff;
  always_ff @(posedge clock_i) begin
    sda_lvl_ff <= 1'b0;
  end

  assign sda_o           = sda_lvl_ff;
  assign sda_oe_o        = oe_ff;
  assign wiper_pos_ch0_o = wiper0_ff;
  assign wiper_pos_ch1_o = wiper1_ff;
  assign power_down_n_o  = ctrl_ff[CTRL_PD_BIT];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i || !clk_en_i);

  a_msb_first_tx: assert property (
    (state_ff == ST_SEND && scl_fall && bits_ff != BITS_PER_BYTE)
      |=> (oe_ff == ~$past(shift_ff[6])))
    else $error("transmit bit order wrong");

  a_sda_scl_low: assert property (
    $changed(oe_ff) |-> !scl_q_ff)
    else $error("sda drive changed with scl high");

  a_powerup_quiet: assert property (
    !pwr_done |=> (state_ff == ST_IDLE && !oe_ff))
    else $error("activity during power-up");

  a_idle_holds: assert property (
    (state_ff == ST_IDLE && !start_seen) |=> state_ff == ST_IDLE)
    else $error("left idle without start");

  a_stop_idle: assert property (
    stop_seen |=> (state_ff == ST_IDLE && !oe_ff) [*2])
    else $error("stop did not return to idle");

  a_ack_ninth: assert property (
    (state_ff == ST_RECV && scl_fall && bits_ff == BITS_PER_BYTE
     && phase_ff != PH_ID && !stop_seen && !start_seen)
      |=> (oe_ff && state_ff == ST_SACK))
    else $error("byte not acknowledged");

  a_id_reject: assert property (
    (state_ff == ST_RECV && scl_fall && bits_ff == BITS_PER_BYTE
     && phase_ff == PH_ID && !id_ok) |=> (state_ff == ST_IDLE && !oe_ff))
    else $error("foreign id accepted");

  a_write_ninth: assert property (
    (state_ff == ST_SACK && scl_rise && phase_ff == PH_DATA
     && ptr_ff == REG_WIPER0 && !stop_seen && !start_seen)
      |=> wiper0_ff == $past(shift_ff))
    else $error("wiper 0 not stored on ninth clock");

  a_ptr_advance: assert property (
    (state_ff == ST_SEND && scl_fall && bits_ff == BITS_PER_BYTE
     && !stop_seen && !start_seen) |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer did not advance");

  a_nack_release: assert property (
    (state_ff == ST_MACK && scl_rise && sda_s)
      |=> (state_ff == ST_IDLE && !oe_ff))
    else $error("read not ended by nack");

  a_ctrl_fields: assert property (
    (ctrl_ff & ~CTRL_WMASK) == 8'h00)
    else $error("reserved control bits set");

  c_write_done: cover property (
    state_ff == ST_SACK && phase_ff == PH_DATA && scl_rise);
  c_read_byte: cover property (
    state_ff == ST_SEND ##[1:1000] state_ff == ST_MACK);
  c_read_more: cover property (
    state_ff == ST_MACK && bits_ff == ACK_SEEN && scl_fall);
  c_repeat_start: cover property (
    start_seen && state_ff == ST_RECV && phase_ff == PH_DATA);

endmodule

`default_nettype wire

// >>> rtl/dpi2c_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is independent; no bus coherency across bits
`timescale 1ns/100ps
`default_nettype none

module dpi2c_sync #(
  parameter int unsigned      WIDTH       = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // first stage feeds only the second stage
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  // idle bus lines are high, so reset to the idle level
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      meta_ff <= RESET_VALUE;
      sync_ff <= RESET_VALUE;
    end else if (clk_en_i) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire
